// ===== core/conv_ctrl.sv
// Converter control, result formatting and AXI4-Lite register slave
`timescale 1ns/1ns
module conv_ctrl
  import conv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vector_ack,
  input wire raw_result_s raw_result,
  output analog_sel_s analog_sel,
  output logic sample_strobe,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] select_reg;
  logic bipolar_reg;
  logic ref_high_reg;
  logic mux5_reg;
  logic enable_reg;
  logic start_reg;
  logic done_reg;
  logic [9:0] result_reg;
  logic irq_en_reg;
  logic long_pending_reg;
  logic first_after_en_reg;
  conv_state_e state_reg;
  logic [4:0] count_reg;
  logic [4:0] count_len_reg;
  analog_sel_s active_reg;

  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  logic wr_fire;
  logic wr_lane0;
  logic conv_done;
  logic [2:0] shadow_ref;
  logic [5:0] shadow_chan;
  logic ref_change;
  logic start_req;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && wstrb_reg[0];
  assign shadow_ref = {ref_high_reg, select_reg[SEL_REF_HI], select_reg[SEL_REF_LO]};
  assign shadow_chan = {mux5_reg, select_reg[4:0]};
  assign conv_done = (state_reg == ST_CONV) && (count_reg == count_len_reg);
  assign ref_change = wr_lane0 && (((awaddr_reg == OFS_SELECT)
      && (wdata_reg[7:6] != select_reg[7:6]))
      || ((awaddr_reg == OFS_CTRL_B) && (wdata_reg[CTRL_B_REF_HIGH] != ref_high_reg)));
  // Start counts when written together with enable, also from the disabled state
  assign start_req = wr_lane0 && (awaddr_reg == OFS_CTRL_A) && wdata_reg[CTRL_A_EN]
      && wdata_reg[CTRL_A_START];

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction

  // Formats the raw conversion into the 10-bit code
  function automatic logic [9:0] format_result(input raw_result_s r, input logic bip);
    logic [10:0] m;
    m = r.magnitude;
    if (!r.differential || !bip)
    begin
      if (r.differential && r.negative)
        format_result = CODE_ZERO;
      else if (m > {1'b0, CODE_MAX})
        format_result = CODE_MAX;
      else
        format_result = m[9:0];
    end
    else if (r.negative)
    begin
      if (m >= 11'd512)
        format_result = BIP_MIN;
      else
        format_result = 10'(~{1'b0, m[8:0]} + 10'd1);
    end
    else if (m > 11'd511)
      format_result = BIP_MAX;
    else
      format_result = {1'b0, m[8:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
    end
    else if (wr_fire)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_reg)
          OFS_SELECT, OFS_CTRL_A, OFS_CTRL_B, OFS_IRQ_ENABLE, OFS_IRQ_CLEAR:
            s_axi_bresp <= RESP_OKAY;
          default:
            s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers (shadow selection)
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      select_reg <= SELECT_RESET;
      bipolar_reg <= 1'b0;
      ref_high_reg <= 1'b0;
      mux5_reg <= 1'b0;
      enable_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end
    else if (wr_lane0)
    begin
      if (is_addr(awaddr_reg, OFS_SELECT))
        select_reg <= wdata_reg[7:0];
      if (is_addr(awaddr_reg, OFS_CTRL_B))
      begin
        bipolar_reg <= wdata_reg[CTRL_B_BIPOLAR];
        ref_high_reg <= wdata_reg[CTRL_B_REF_HIGH];
        mux5_reg <= wdata_reg[CTRL_B_MUX5];
      end
      if (is_addr(awaddr_reg, OFS_CTRL_A))
        enable_reg <= wdata_reg[CTRL_A_EN];
      if (is_addr(awaddr_reg, OFS_IRQ_ENABLE))
        irq_en_reg <= wdata_reg[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      count_reg <= 5'd0;
      count_len_reg <= 5'(NORMAL_CYCLES);
      start_reg <= 1'b0;
      sample_strobe <= 1'b0;
    end
    else
    begin
      sample_strobe <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req)
          begin
            state_reg <= ST_CONV;
            start_reg <= 1'b1;
            count_reg <= 5'd1;
            count_len_reg <= (long_pending_reg || first_after_en_reg || ref_change)
                ? 5'(LONG_CYCLES) : 5'(NORMAL_CYCLES);
          end
        end
        ST_CONV:
        begin
          if (!enable_reg)
          begin
            state_reg <= ST_IDLE;
            start_reg <= 1'b0;
          end
          else if (conv_done)
          begin
            state_reg <= ST_DONE;
            sample_strobe <= 1'b1;
          end
          else
            count_reg <= count_reg + 5'd1;
        end
        ST_DONE:
        begin
          state_reg <= ST_IDLE;
          start_reg <= 1'b0;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Long conversion is owed after enable or after any reference change
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      long_pending_reg <= 1'b0;
      first_after_en_reg <= 1'b1;
    end
    else
    begin
      if (ref_change)
        long_pending_reg <= 1'b1;
      else if (state_reg == ST_CONV && count_reg == 5'd1)
        long_pending_reg <= 1'b0;
      if (!enable_reg)
        first_after_en_reg <= 1'b1;
      else if (state_reg == ST_CONV)
        first_after_en_reg <= 1'b0;
    end
  end

  // Active selection follows the shadow except while a conversion holds it
  always_ff @(posedge clk)
  begin
    if (srst)
      active_reg <= '0;
    else if (state_reg != ST_CONV || conv_done)
    begin
      active_reg.channel_selector <= shadow_chan;
      active_reg.ref_code <= shadow_ref;
      active_reg.temp_enable <= (shadow_chan == CHAN_TEMP);
      active_reg.bipolar_select <= bipolar_reg;
    end
  end
  assign analog_sel = active_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Result capture and completion flag
  always_ff @(posedge clk)
  begin
    if (srst)
      result_reg <= CODE_ZERO;
    else if (conv_done && enable_reg)
      result_reg <= format_result(raw_result, active_reg.bipolar_select);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      done_reg <= 1'b0;
    else if (conv_done && enable_reg)
      done_reg <= 1'b1;
    else if (vector_ack || (wr_lane0 && ((is_addr(awaddr_reg, OFS_CTRL_A)
        && wdata_reg[CTRL_A_DONE]) || (is_addr(awaddr_reg, OFS_IRQ_CLEAR) && wdata_reg[0]))))
      done_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= done_reg && irq_en_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic [15:0] presented;
  assign presented = select_reg[SEL_LEFT_ADJ] ? {result_reg, 6'h00} : {6'h00, result_reg};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_SELECT: s_axi_rdata <= {24'h0, select_reg};
        OFS_CTRL_A: s_axi_rdata <= {24'h0, enable_reg, start_reg, 1'b0, done_reg, 4'h0};
        OFS_CTRL_B: s_axi_rdata <= {24'h0, bipolar_reg, 2'b00, ref_high_reg, mux5_reg, 3'h0};
        OFS_RES_LOW: s_axi_rdata <= {24'h0, presented[7:0]};
        OFS_RES_HIGH: s_axi_rdata <= {24'h0, presented[15:8]};
        OFS_IRQ_STATUS: s_axi_rdata <= {31'h0, done_reg};
        OFS_IRQ_ENABLE: s_axi_rdata <= {31'h0, irq_en_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else
      s_axi_arready <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_long_after_ref: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_IDLE && long_pending_reg ##1 state_reg == ST_CONV
      |-> count_len_reg == 5'(LONG_CYCLES)) else $error("ref change not long");
  a_sel_locked: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_CONV && !conv_done |=> $stable(active_reg.ref_code))
      else $error("reference changed mid conversion");
  a_temp_enable: assert property (@(posedge clk) disable iff (srst)
      active_reg.temp_enable == (active_reg.channel_selector == CHAN_TEMP))
      else $error("temperature enable mismatch");
  a_done_sets: assert property (@(posedge clk) disable iff (srst)
      conv_done && enable_reg |=> done_reg && state_reg == ST_DONE)
      else $error("done flag not set");
  a_irq_follows: assert property (@(posedge clk) disable iff (srst)
      done_reg && irq_en_reg |=> irq) else $error("interrupt missing");
  a_bip_default: assert property (@(posedge clk) srst |=> !bipolar_reg)
      else $error("bipolar after reset");
  a_clamp_zero: assert property (@(posedge clk) disable iff (srst)
      conv_done && enable_reg && raw_result.differential && raw_result.negative
      && !active_reg.bipolar_select |=> result_reg == CODE_ZERO)
      else $error("unipolar not clamped");
  a_sign_bit: assert property (@(posedge clk) disable iff (srst)
      conv_done && enable_reg && raw_result.differential && active_reg.bipolar_select
      && raw_result.magnitude != 11'd0 |=> result_reg[9] == $past(raw_result.negative))
      else $error("sign bit wrong");
  a_normal_len: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_CONV |-> count_len_reg inside {5'(NORMAL_CYCLES), 5'(LONG_CYCLES)})
      else $error("bad conversion length");
endmodule

// ===== include/conv_pkg.sv
// Constants, types and register map for the converter control block
// What this block does
// - Single-ended result is unsigned 10-bit code, ground zero, top 0x3ff.
// - Unipolar differential result unsigned, gain scaled, negative difference clamps to zero.
// - Unipolar by default; bipolar only while the bipolar select bit is one.
// - Bipolar differential result is 10-bit two's complement, 0x200 to 0x1ff.
// - In bipolar mode the differential result bit nine, in high byte, gives the sign; single-ended results stay unsigned.
// - Channel selector all ones routes and enables the temperature sensor.
// - Three-bit reference code selects supply, pin, 1.1 V, reserved or 2.56 V.
// - Reference writes during a conversion apply only after it completes or is aborted by clearing enable.
// - After any reference change the next conversion takes 25 cycles.
// - Result readable in low and high result bytes once done flag is set.
// - Left adjust bit changes result presentation immediately.
// - Done flag set at completion; cleared by vector acknowledge or writing one.
package conv_pkg;
  localparam logic [7:0] OFS_SELECT = 8'h1c;
  localparam logic [7:0] OFS_CTRL_A = 8'h18;
  localparam logic [7:0] OFS_CTRL_B = 8'h0c;
  localparam logic [7:0] OFS_RES_LOW = 8'h10;
  localparam logic [7:0] OFS_RES_HIGH = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam int SEL_REF_HI = 7;
  localparam int SEL_REF_LO = 6;
  localparam int SEL_LEFT_ADJ = 5;
  localparam int CTRL_A_EN = 7;
  localparam int CTRL_A_START = 6;
  localparam int CTRL_A_DONE = 4;
  localparam int CTRL_B_BIPOLAR = 7;
  localparam int CTRL_B_REF_HIGH = 4;
  localparam int CTRL_B_MUX5 = 3;
  localparam logic [5:0] CHAN_TEMP = 6'h3f;
  localparam int NORMAL_CYCLES = 13;
  localparam int LONG_CYCLES = 25;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] BIP_MIN = 10'h200;
  localparam logic [9:0] BIP_MAX = 10'h1ff;
  localparam logic [2:0] REF_SUPPLY = 3'h0;
  localparam logic [2:0] REF_PIN = 3'h1;
  localparam logic [2:0] REF_INT_1V1 = 3'h2;
  localparam logic [2:0] REF_RESERVED = 3'h3;
  localparam logic [2:0] REF_2V56 = 3'h6;
  localparam logic [2:0] REF_2V56_BYP = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONV = 2'b01, ST_DONE = 2'b11} conv_state_e;

  // Selection that drives the analog front end
  typedef struct packed {
    logic [5:0] channel_selector;
    logic [2:0] ref_code;
    logic temp_enable;
    logic bipolar_select;
  } analog_sel_s;

  // Raw answer of the analog core
  typedef struct packed {
    logic differential;
    logic negative;
    logic [10:0] magnitude;
  } raw_result_s;
endpackage

// ===== testbench/adc_result_and_reference_control_test.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ns
module adc_result_and_reference_control_test;
  import conv_pkg::*;
  typedef struct packed {
    logic bip;
    logic dif;
    logic neg;
    logic lft;
    logic [10:0] mag;
    logic [7:0] lo;
    logic [7:0] hi;
  } row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic vector_ack = 1'b0;
  raw_result_s raw_result;
  raw_result_s stim = '0;
  analog_sel_s analog_sel;
  logic sample_strobe;
  logic irq;
  int failures = 0;
  int checks = 0;
  int c;
  int n0;
  logic [31:0] d;
  logic [1:0] r;
  logic [1:0] br = 2'h0;
  row_s rows [10] = '{
    '{0, 0, 0, 0, 11'h000, 8'h00, 8'h00}, '{0, 0, 0, 0, 11'h3ff, 8'hff, 8'h03},
    '{0, 0, 0, 0, 11'h500, 8'hff, 8'h03}, '{0, 1, 1, 0, 11'h005, 8'h00, 8'h00},
    '{0, 1, 0, 0, 11'h123, 8'h23, 8'h01}, '{1, 1, 1, 0, 11'h001, 8'hff, 8'h03},
    '{1, 1, 1, 0, 11'h200, 8'h00, 8'h02}, '{1, 1, 0, 0, 11'h1ff, 8'hff, 8'h01},
    '{1, 1, 0, 0, 11'h300, 8'hff, 8'h01}, '{0, 0, 0, 1, 11'h3ff, 8'hc0, 8'hff}};

  conv_ctrl dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .vector_ack, .raw_result, .analog_sel, .sample_strobe, .irq);
  analog_front_model model (.sel(analog_sel), .stim(stim), .raw(raw_result));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (g !== e)
      begin
        $display("BAD %s expected %h seen %h", nm, e, g);
        failures++;
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    logic got;
    begin
      got = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 100 && !got; n++)
      begin
        @(posedge clk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          got = 1'b1;
          br = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
      end
      chk("write answer", 1, got);
    end
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic got;
    begin
      got = 1'b0;
      v = 32'h0;
      rs = 2'h0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 100 && !got; n++)
      begin
        @(posedge clk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          got = 1'b1;
          v = s_axi_rdata;
          rs = s_axi_rresp;
          s_axi_rready <= 1'b0;
        end
      end
      chk("read answer", 1, got);
    end
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    begin
      rd(a, v, rs);
      chk(nm, e, v);
      chk("read resp", RESP_OKAY, rs);
    end
  endtask

  // Counts edges until the end-of-conversion pulse
  task wait_end(output int n);
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (n < 60 && !sample_strobe);
    end
  endtask

  task conv(output int n);
    begin
      wr(OFS_CTRL_A, 8'hc0);
      wait_end(n);
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    $display("BAD watchdog expected finish seen timeout");
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc("select reset", OFS_SELECT, {24'h0, SELECT_RESET});
    chk("bipolar default", 0, analog_sel.bipolar_select);
    chk("irq reset", 0, irq);
    $display("reset test done");
    wr(OFS_CTRL_A, 8'h80);
    foreach (rows[i])
    begin
      wr(OFS_CTRL_B, {rows[i].bip, 7'h00});
      wr(OFS_SELECT, {2'b00, rows[i].lft, 5'h00});
      chk("bipolar select", rows[i].bip, analog_sel.bipolar_select);
      stim <= '{rows[i].dif, rows[i].neg, rows[i].mag};
      conv(c);
      rc("result low", OFS_RES_LOW, rows[i].lo);
      rc("result high", OFS_RES_HIGH, rows[i].hi);
    end
    wr(OFS_SELECT, 8'h00);
    rc("adjust now", OFS_RES_HIGH, 32'h03);
    $display("result table done");
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4 || k == 5)
        continue;
      wr(OFS_CTRL_B, {3'h0, k[2], 4'h0});
      wr(OFS_SELECT, {k[1:0], 6'h00});
      rc("select rw", OFS_SELECT, {24'h0, k[1:0], 6'h00});
      chk("ref code", k[2:0], analog_sel.ref_code);
    end
    $display("reference codes done");
    wr(OFS_CTRL_B, 8'h08);
    wr(OFS_SELECT, 8'h9f);
    conv(c);
    chk("temp channel", CHAN_TEMP, analog_sel.channel_selector);
    chk("temp enable", 1, analog_sel.temp_enable);
    rc("temp low", OFS_RES_LOW, 32'h2c);
    rc("temp high", OFS_RES_HIGH, 32'h01);
    $display("temperature test done");
    conv(n0);
    chk("normal conversion", NORMAL_CYCLES, n0);
    wr(OFS_CTRL_A, 8'hc0);
    wr(OFS_SELECT, 8'h5f);
    chk("ref held", REF_INT_1V1, analog_sel.ref_code);
    wait_end(c);
    @(posedge clk);
    @(posedge clk);
    chk("ref applied", REF_PIN, analog_sel.ref_code);
    conv(c);
    chk("long conversion", LONG_CYCLES, c);
    $display("deferred reference test done");
    wr(OFS_IRQ_ENABLE, 8'h01);
    rc("status set", OFS_IRQ_STATUS, 32'h1);
    chk("irq on", 1, irq);
    wr(OFS_CTRL_A, 8'h90);
    rc("flag write clear", OFS_IRQ_STATUS, 32'h0);
    chk("irq off", 0, irq);
    conv(c);
    @(posedge clk);
    chk("irq before ack", 1, irq);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    rc("vector clear", OFS_IRQ_STATUS, 32'h0);
    conv(c);
    wr(OFS_IRQ_CLEAR, 8'h01);
    rc("clear reg", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_IRQ_ENABLE, 8'h00);
    conv(c);
    rc("masked status", OFS_IRQ_STATUS, 32'h1);
    chk("irq masked", 0, irq);
    $display("interrupt test done");
    wr(OFS_IRQ_CLEAR, 8'h01);
    wr(OFS_CTRL_A, 8'hc0);
    wr(OFS_CTRL_A, 8'h00);
    repeat (30) @(posedge clk);
    rc("abort no flag", OFS_IRQ_STATUS, 32'h0);
    conv(c);
    chk("first after enable", LONG_CYCLES, c);
    rc("status after restart", OFS_IRQ_STATUS, 32'h1);
    $display("abort test done");
    rd(8'h30, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", 0, d);
    wr(8'h30, 8'h55);
    chk("unmapped bresp", RESP_SLVERR, br);
    wr(OFS_IRQ_ENABLE, 8'h00);
    chk("mapped bresp", RESP_OKAY, br);
    $display("unmapped test done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("irq after reset", 0, irq);
    chk("ref after reset", REF_SUPPLY, analog_sel.ref_code);
    rc("status after reset", OFS_IRQ_STATUS, 32'h0);
    $display("mid reset test done");
    wrap_up();
  end
endmodule

// ===== testbench/analog_front_model.sv
// Behavioural analog front end that answers the converter control block
`timescale 1ns/1ns
module analog_front_model
  import conv_pkg::*;
#(
  parameter logic [10:0] TEMP_CODE = 11'h12c
)
(
  input analog_sel_s sel,
  input raw_result_s stim,
  output raw_result_s raw
);
  // Sensor answers single-ended, only while routed and enabled
  always_comb
  begin
    raw = stim;
    if (sel.temp_enable && sel.channel_selector == CHAN_TEMP)
    begin
      raw = '{differential: 1'b0, negative: 1'b0, magnitude: TEMP_CODE};
    end
  end
endmodule
